// ---- logic/counter_capture_regs.sv ----
/*
 * Register access for the 16-bit programmable counter array with six
 * capture/compare modules: counter bytes with high-byte snapshot, write lock
 * under the watchdog, module value bytes and their reload alias.
 * Assumes a synchronous special-register port: one-cycle read and write
 * strobes, address and data in the mclk_in domain; read data one cycle later.
 */
// Contract
// - Counter high-byte register holds upper eight bits of the 16-bit counter.
// - High-byte reads return a snapshot refreshed only when the low byte is read.
// - Counter high-byte writes are ignored while watchdog_enable is 1.
// - Each of six modules holds a 16-bit value; high byte at its high address.
// - Writing a module low byte clears its comparator enable.
// - Writing a module high byte sets its comparator enable.
// - High-byte address reaches the reload high byte when reload_select is set.
// - reload_select 0 picks value registers, 1 picks reload registers.
// - Counter low-byte writes are ignored while watchdog_enable is 1.
// - A set comparator enable turns on that module's comparator.
module counter_capture_regs
    import counter_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   srst_in,
    // Register port
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic [7:0]             reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    output logic      [7:0]             reg_rdata_out,
    // Counter control from the array
    input  wire logic                   count_enable_in,
    input  wire logic                   watchdog_enable_in,
    // Block state
    output logic      [15:0]            counter_out,
    output logic      [NUM_MODULES-1:0] compare_enable_out,
    output logic                        reload_select_out
);

    typedef struct packed {
        logic [15:0]            counter;
        logic [7:0]             snapshot;
        logic                   reload_select;
        logic [7:0]             rdata;
        logic [NUM_MODULES-1:0] compare_enable;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    logic [NUM_MODULES-1:0] wr_low;
    logic [NUM_MODULES-1:0] wr_high;
    logic [NUM_MODULES-1:0] wr_mode;
    logic [15:0]            value  [NUM_MODULES];
    logic [15:0]            reload [NUM_MODULES];
    logic [7:0]             mode   [NUM_MODULES];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g++) begin : gen_slot
            assign wr_low[g]  = reg_wr_in && hit(reg_addr_in, ADDR_VALUE_LOW[g]);
            assign wr_high[g] = reg_wr_in && hit(reg_addr_in, ADDR_VALUE_HIGH[g]);
            // The last module's mode doubles as the watchdog and is frozen with it
            assign wr_mode[g] = reg_wr_in && hit(reg_addr_in, ADDR_MODE[g])
                                && !(g == NUM_MODULES - 1 && watchdog_enable_in);
            module_value_slot u_slot (
                .mclk_in          (mclk_in),
                .srst_in          (srst_in),
                .wr_low_in        (wr_low[g]),
                .wr_high_in       (wr_high[g]),
                .wr_mode_in       (wr_mode[g]),
                .reload_select_in (state_reg.reload_select),
                .wdata_in         (reg_wdata_in),
                .value_out        (value[g]),
                .reload_out       (reload[g]),
                .mode_out         (mode[g])
            );
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.rdata = RESET_BYTE;
        if (count_enable_in) begin
            state_next.counter = state_reg.counter + 16'h0001;
        end
        if (reg_wr_in && !watchdog_enable_in) begin
            if (hit(reg_addr_in, ADDR_COUNTER_LOW)) begin
                state_next.counter[7:0] = reg_wdata_in;
            end
            if (hit(reg_addr_in, ADDR_COUNTER_HIGH)) begin
                state_next.counter[15:8] = reg_wdata_in;
            end
        end
        if (reg_wr_in && hit(reg_addr_in, ADDR_PWM_CONTROL)) begin
            state_next.reload_select = reg_wdata_in[RELOAD_SELECT_BIT];
        end
        if (reg_rd_in) begin
            if (hit(reg_addr_in, ADDR_COUNTER_LOW)) begin
                state_next.rdata    = state_reg.counter[7:0];
                state_next.snapshot = state_reg.counter[15:8];
            end
            if (hit(reg_addr_in, ADDR_COUNTER_HIGH)) begin
                state_next.rdata = state_reg.snapshot;
            end
            if (hit(reg_addr_in, ADDR_PWM_CONTROL)) begin
                state_next.rdata = {state_reg.reload_select, 7'h00};
            end
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (hit(reg_addr_in, ADDR_VALUE_LOW[i])) begin
                    state_next.rdata = state_reg.reload_select ? reload[i][7:0]
                                                               : value[i][7:0];
                end
                if (hit(reg_addr_in, ADDR_VALUE_HIGH[i])) begin
                    state_next.rdata = state_reg.reload_select ? reload[i][15:8]
                                                               : value[i][15:8];
                end
                if (hit(reg_addr_in, ADDR_MODE[i])) begin
                    state_next.rdata = mode[i];
                end
            end
        end
        for (int i = 0; i < NUM_MODULES; i++) begin
            state_next.compare_enable[i] = mode[i][COMPARE_ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out      = state_reg.rdata;
    assign counter_out        = state_reg.counter;
    assign compare_enable_out = state_reg.compare_enable;
    assign reload_select_out  = state_reg.reload_select;

endmodule

// ---- common/counter_regs_pkg.sv ----
/*
 * Constants for the counter-array register block: register addresses,
 * reset values and field positions of the control bits it touches.
 * Assumes an 8-bit special-register space with byte addresses.
 */
package counter_regs_pkg;

    localparam int NUM_MODULES = 6;

    localparam logic [7:0] ADDR_COUNTER_LOW  = 8'hf9;
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
    localparam logic [7:0] ADDR_PWM_CONTROL  = 8'hdf;

    // Low and high byte addresses, indexed by module number
    localparam logic [7:0] ADDR_VALUE_LOW  [NUM_MODULES] =
        '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
    localparam logic [7:0] ADDR_VALUE_HIGH [NUM_MODULES] =
        '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};

    localparam logic [7:0] ADDR_MODE [NUM_MODULES] =
        '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Field positions
    localparam int RELOAD_SELECT_BIT   = 7;
    localparam int COMPARE_ENABLE_BIT  = 6;

    localparam logic [7:0] PWM_CONTROL_RW_MASK = 8'h80;

endpackage

// ---- logic/module_value_slot.sv ----
/*
 * One capture/compare module: 16-bit value, 16-bit reload value and the
 * comparator-enable bit with its write side effects.
 * Assumes one-cycle write strobes from the register decoder in the same clock.
 */
module module_value_slot
    import counter_regs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Byte writes
    input  wire logic        wr_low_in,
    input  wire logic        wr_high_in,
    input  wire logic        wr_mode_in,
    input  wire logic        reload_select_in,
    input  wire logic [7:0]  wdata_in,
    // State
    output logic      [15:0] value_out,
    output logic      [15:0] reload_out,
    output logic      [7:0]  mode_out
);

    typedef struct packed {
        logic [15:0] value;
        logic [15:0] reload;
        logic [7:0]  mode;
    } slot_state_t;

    slot_state_t state_reg;
    slot_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_mode_in) begin
            state_next.mode = wdata_in;
        end
        // Reload storage shares the addresses, chosen by reload_select
        if (wr_low_in) begin
            if (reload_select_in) begin
                state_next.reload[7:0] = wdata_in;
            end else begin
                state_next.value[7:0] = wdata_in;
            end
            state_next.mode[COMPARE_ENABLE_BIT] = 1'b0;
        end
        if (wr_high_in) begin
            if (reload_select_in) begin
                state_next.reload[15:8] = wdata_in;
            end else begin
                state_next.value[15:8] = wdata_in;
            end
            state_next.mode[COMPARE_ENABLE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign value_out  = state_reg.value;
    assign reload_out = state_reg.reload;
    assign mode_out   = state_reg.mode;

endmodule

// ---- bench/counter_capture_checker.sv ----
/* Checker for counter_capture_regs: counter writes, lock, snapshot, enable side effects.
   Assumes it is bound to the top module and sees only its ports. */
module counter_capture_checker
    import counter_regs_pkg::*;
(
    // Clock, reset, register port
    input wire logic                   mclk_in,
    input wire logic                   srst_in,
    input wire logic                   reg_wr_in,
    input wire logic                   reg_rd_in,
    input wire logic [7:0]             reg_addr_in,
    input wire logic [7:0]             reg_wdata_in,
    input wire logic [7:0]             reg_rdata_out,
    // Array state
    input wire logic                   count_enable_in,
    input wire logic                   watchdog_enable_in,
    input wire logic [15:0]            counter_out,
    input wire logic [NUM_MODULES-1:0] compare_enable_out,
    input wire logic                   reload_select_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    logic       hi0, lo0, m0, cw;
    logic [7:0] snap_reg, snap_next;
    assign hi0 = reg_wr_in && reg_addr_in == ADDR_VALUE_HIGH[0];
    assign lo0 = reg_wr_in && reg_addr_in == ADDR_VALUE_LOW[0];
    assign m0  = reg_wr_in && reg_addr_in == ADDR_MODE[0];
    assign cw  = reg_wr_in && reg_addr_in inside {ADDR_COUNTER_LOW, ADDR_COUNTER_HIGH};
    // Reference copy of the snapshot, taken with the low-byte read
    always_comb snap_next = (reg_rd_in && reg_addr_in == ADDR_COUNTER_LOW)
                            ? counter_out[15:8] : snap_reg;
    always_ff @(posedge mclk_in) snap_reg <= srst_in ? 8'h00 : snap_next;
    sequence hi0_s;
        hi0 && !reload_select_out ##1 !(lo0 || m0);
    endsequence
    sequence lo0_s;
        lo0 && !reload_select_out ##1 !(hi0 || m0);
    endsequence
    hold_a: assert property (
        !count_enable_in && !reg_wr_in |=> $stable(counter_out)) else $error("counter moved");
    step_a: assert property (
        count_enable_in && !reg_wr_in |=> counter_out == $past(counter_out) + 16'h0001)
        else $error("counter step wrong");
    lock_a: assert property (
        cw && watchdog_enable_in && !count_enable_in |=> $stable(counter_out))
        else $error("locked counter written");
    low_write_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_COUNTER_LOW && !watchdog_enable_in
        |=> counter_out[7:0] == $past(reg_wdata_in)) else $error("low byte write lost");
    low_read_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_COUNTER_LOW |=> reg_rdata_out == $past(counter_out[7:0]))
        else $error("low byte read wrong");
    snap_read_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_COUNTER_HIGH |=> reg_rdata_out == $past(snap_reg))
        else $error("snapshot read wrong");
    high_sets_a: assert property (
        hi0_s |=> compare_enable_out[0]) else $error("enable not set");
    low_clears_a: assert property (
        lo0_s |=> !compare_enable_out[0]) else $error("enable not cleared");
    reload_sel_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_PWM_CONTROL
        |=> reload_select_out == $past(reg_wdata_in[RELOAD_SELECT_BIT]))
        else $error("select lost");
endmodule

bind counter_capture_regs counter_capture_checker u_checker (.mclk_in, .srst_in, .reg_wr_in,
    .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .count_enable_in,
    .watchdog_enable_in, .counter_out, .compare_enable_out, .reload_select_out);

// ---- bench/counter_capture_regs_tb.sv ----
/* Self-checking bench for counter_capture_regs, random data with fixed seed.
   Assumes the package and the bound checker are compiled before it. */
module counter_capture_regs_tb
    import counter_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, cen = 0, wde = 0, rs;
    logic [7:0]  addr = 0, wdata = 0, rdata, d, m;
    logic [7:0]  vm [12];
    logic [15:0] cnt, e;
    logic [5:0]  ce;
    int          mismatches = 0, compares = 0;
    counter_capture_regs u_dut (.mclk_in(clk), .srst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .count_enable_in(cen), .watchdog_enable_in(wde), .counter_out(cnt),
        .compare_enable_out(ce), .reload_select_out(rs));
    initial forever #5 clk = ~clk;
    task results;
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_count(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A spare edge before each access keeps strobes from being driven twice in one step
    task wrr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 d = rdata;
    endtask
    function automatic logic [15:0] after_count(logic [15:0] b, int n);
        return b + 16'(n);
    endfunction
    initial begin
        void'($urandom(27780));
        repeat (5) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 6; i++) begin
            vm[i] = 8'($urandom);
            vm[i+6] = 8'($urandom);
            rdr(ADDR_VALUE_HIGH[i]);
            chk(d, RESET_BYTE);
            wrr(ADDR_VALUE_HIGH[i], vm[i]);
            rdr(ADDR_VALUE_HIGH[i]);
            chk(d, vm[i]);
            chk({7'h0, ce[i]}, 8'h01);
            wrr(ADDR_VALUE_LOW[i], vm[i+6]);
            rdr(ADDR_VALUE_LOW[i]);
            chk(d, vm[i+6]);
            chk({7'h0, ce[i]}, 8'h00);
        end
        // Only the select bit is writable; the others must read back as zero
        wrr(ADDR_PWM_CONTROL, 8'hff);
        rdr(ADDR_PWM_CONTROL);
        chk(d, PWM_CONTROL_RW_MASK);
        for (int i = 0; i < 6; i++) begin
            wrr(ADDR_VALUE_HIGH[i], ~vm[i]);
            wrr(ADDR_VALUE_LOW[i], vm[i]);
            rdr(ADDR_VALUE_HIGH[i]);
            chk(d, ~vm[i]);
            rdr(ADDR_VALUE_LOW[i]);
            chk(d, vm[i]);
        end
        chk({7'h0, rs}, 8'h01);
        wrr(ADDR_PWM_CONTROL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rdr(ADDR_VALUE_HIGH[i]);
            chk(d, vm[i]);
            rdr(ADDR_VALUE_LOW[i]);
            chk(d, vm[i+6]);
        end
        wrr(ADDR_COUNTER_LOW, 8'hfe);
        wrr(ADDR_COUNTER_HIGH, 8'h12);
        cen <= 1;
        repeat (5) @(posedge clk);
        cen <= 0;
        e = after_count(16'h12fe, 5);
        rdr(ADDR_COUNTER_LOW);
        chk(d, e[7:0]);
        chk_count(cnt, e);
        wrr(ADDR_COUNTER_HIGH, 8'h55);
        rdr(ADDR_COUNTER_HIGH);
        chk(d, e[15:8]);
        rdr(ADDR_COUNTER_LOW);
        rdr(ADDR_COUNTER_HIGH);
        chk(d, 8'h55);
        m = 8'($urandom);
        wrr(ADDR_MODE[5], m);
        rdr(ADDR_MODE[5]);
        chk(d, m);
        chk({7'h0, ce[5]}, {7'h0, m[COMPARE_ENABLE_BIT]});
        @(posedge clk);
        wde <= 1;
        wrr(ADDR_COUNTER_LOW, 8'haa);
        wrr(ADDR_COUNTER_HIGH, 8'haa);
        rdr(ADDR_COUNTER_LOW);
        chk(d, e[7:0]);
        rdr(ADDR_COUNTER_HIGH);
        chk(d, 8'h55);
        // The watchdog freezes only the last module's mode byte
        wrr(ADDR_MODE[5], ~m);
        wrr(ADDR_MODE[0], ~m);
        rdr(ADDR_MODE[5]);
        chk(d, m);
        rdr(ADDR_MODE[0]);
        chk(d, ~m);
        chk({7'h0, ce[0]}, {7'h0, ~m[COMPARE_ENABLE_BIT]});
        // Low read while counting across a byte boundary: both bytes must match
        wde <= 0;
        wrr(ADDR_COUNTER_LOW, 8'hfe);
        cen <= 1;
        rdr(ADDR_COUNTER_LOW);
        cen <= 0;
        e = after_count(16'h55fe, 1);
        chk(d, e[7:0]);
        rdr(ADDR_COUNTER_HIGH);
        chk(d, e[15:8]);
        // Mid-run reset with nonzero counter, select and enable outputs; read data is zero
        wrr(ADDR_VALUE_HIGH[0], 8'h5a);
        wrr(ADDR_PWM_CONTROL, 8'h80);
        @(posedge clk);
        rst <= 1;
        repeat (5) @(posedge clk);
        rst <= 0;
        rdr(ADDR_COUNTER_LOW);
        chk(d, RESET_BYTE);
        chk_count(cnt, {RESET_BYTE, RESET_BYTE});
        chk({7'h0, rs}, 8'h00);
        chk({2'h0, ce}, 8'h00);
        rdr(ADDR_VALUE_HIGH[0]);
        chk(d, RESET_BYTE);
        results();
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule
